// File: inc/scaci_pkg.sv
package scaci_pkg;

  // ----------------------------------------
  // widths and bit positions
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int NUM_MODE_REGS = 4;
  localparam int AP_BIT = 10;
  localparam int TERM_DIS_BIT = 6;
  localparam int WORD_W = ADDR_W + BANK_W + 6;

  // ----------------------------------------
  // command codes {ras_n, cas_n, we_n}
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_LOAD_MODE = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVATE = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_TERMINATE = 3'h6,
    CMD_NOP = 3'h7
  } scaci_cmd_t;

  // ----------------------------------------
  // mode register select on bank_select
  // ----------------------------------------
  localparam logic [1:0] SEL_BASE_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT_MODE_1 = 2'h1;
  localparam logic [1:0] SEL_EXT_MODE_2 = 2'h2;
  localparam logic [1:0] SEL_EXT_MODE_3 = 2'h3;

  // ----------------------------------------
  // power states
  // ----------------------------------------
  typedef enum logic [3:0] {
    PW_ACTIVE = 4'h1,
    PW_PRE_PD = 4'h2,
    PW_ACT_PD = 4'h4,
    PW_SELF_REF = 4'h8
  } scaci_pwr_t;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYS_CLK_MHZ = 100;
  localparam int LINK_IDLE_NS = 400;
  localparam int LINK_IDLE_CYC = (LINK_IDLE_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [ADDR_W-1:0] MODE_REG_RST = 14'h0000;

endpackage

// File: rtl/scaci_input_stage.sv
`timescale 1ns/100ps
module scaci_input_stage
  import scaci_pkg::*;
#(
  parameter int LINK_IDLE = LINK_IDLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic diff_clock_true,
  input wire logic diff_clock_comp,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] row_col_address_bus,
  input wire logic [BANK_W-1:0] bank_select,
  input wire logic cke,
  input wire logic termination_ctrl,
  output logic cmd_strobe_ff,
  output scaci_cmd_t cmd_kind_ff,
  output logic [BANK_W-1:0] cmd_bank_ff,
  output logic [ADDR_W-1:0] cmd_addr_ff,
  output logic auto_pre_ff,
  output logic pre_all_ff,
  output logic [NUM_BANKS-1:0] bank_open_ff,
  output logic [ADDR_W-1:0] base_mode_reg,
  output logic [ADDR_W-1:0] ext_mode_reg_1,
  output logic [ADDR_W-1:0] ext_mode_reg_2,
  output logic [ADDR_W-1:0] ext_mode_reg_3,
  output scaci_pwr_t pwr_state_ff,
  output logic int_clk_en_ff,
  output logic out_enable_ff,
  output logic term_enable_ff,
  output logic data_launch_ff,
  output logic link_clock_running_ff
);

  // ----------------------------------------
  // link domain reset
  // ----------------------------------------
  logic [1:0] lrst_ff;
  logic link_rst_n;

  always_ff @(posedge diff_clock_true or negedge rst_n)
  begin
    if (!rst_n)
      lrst_ff <= 2'h0;
    else
      lrst_ff <= {lrst_ff[0], 1'b1};
  end
  assign link_rst_n = lrst_ff[1];

  // ----------------------------------------
  // link domain capture
  // ----------------------------------------
  logic [1:0] gate_sys;
  logic [1:0] gate_lk;
  logic pd_gate;
  logic sr_gate;
  logic cke_lk_ff;
  logic term_lk_ff;
  logic cs_n_lk_ff;
  logic [2:0] cmd_lk_ff;
  logic [BANK_W-1:0] bank_lk_ff;
  logic [ADDR_W-1:0] addr_lk_ff;
  logic tgl_lk_ff;

  scaci_sync #(.W(2)) u_gate_sync (
    .clk(diff_clock_true),
    .rst_n(link_rst_n),
    .d(gate_sys),
    .q(gate_lk)
  );
  assign pd_gate = gate_lk[0];
  assign sr_gate = gate_lk[1];

  always_ff @(posedge diff_clock_true or negedge link_rst_n)
  begin
    if (!link_rst_n)
      cke_lk_ff <= 1'b0;
    else
      cke_lk_ff <= cke;
  end

  always_ff @(posedge diff_clock_true or negedge link_rst_n)
  begin
    if (!link_rst_n)
      term_lk_ff <= 1'b0;
    else if (!sr_gate)
      term_lk_ff <= termination_ctrl;
  end

  always_ff @(posedge diff_clock_true or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cs_n_lk_ff <= 1'b1;
      cmd_lk_ff <= CMD_NOP;
      bank_lk_ff <= '0;
      addr_lk_ff <= '0;
    end
    else if (!sr_gate && !pd_gate)
    begin
      cs_n_lk_ff <= cs_n;
      cmd_lk_ff <= {ras_n, cas_n, we_n};
      bank_lk_ff <= bank_select;
      addr_lk_ff <= row_col_address_bus;
    end
    else
      cs_n_lk_ff <= 1'b1;
  end

  always_ff @(posedge diff_clock_true or negedge link_rst_n)
  begin
    if (!link_rst_n)
      tgl_lk_ff <= 1'b0;
    else if (!sr_gate)
      tgl_lk_ff <= ~tgl_lk_ff;
  end

  sr_hold_a: assert property (@(posedge diff_clock_true) disable iff (!link_rst_n)
    sr_gate |=> $stable(addr_lk_ff) && $stable(term_lk_ff) && $stable(tgl_lk_ff))
    else $error("inputs sampled during self refresh");

  pd_gate_a: assert property (@(posedge diff_clock_true) disable iff (!link_rst_n)
    pd_gate |=> cs_n_lk_ff)
    else $error("command pins sampled during power-down");

  // ----------------------------------------
  // system domain crossings
  // ----------------------------------------
  logic tgl_s;
  logic cke_async_s;
  logic comp_s;
  logic tgl_seen_ff;
  logic new_word;

  scaci_sync #(.W(3)) u_sys_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d({tgl_lk_ff, cke, diff_clock_comp}),
    .q({tgl_s, cke_async_s, comp_s})
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tgl_seen_ff <= 1'b0;
    else
      tgl_seen_ff <= tgl_s;
  end
  assign new_word = tgl_s ^ tgl_seen_ff;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  scaci_cmd_t cmd_w;
  logic any_open;
  logic cmd_go;
  logic sr_entry;

  assign cmd_w = scaci_cmd_t'(cmd_lk_ff);
  assign any_open = |bank_open_ff;
  assign cmd_go = new_word && !cs_n_lk_ff && cke_lk_ff
    && pwr_state_ff == PW_ACTIVE;
  assign sr_entry = !cs_n_lk_ff && cmd_w == CMD_REFRESH;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_strobe_ff <= 1'b0;
      cmd_kind_ff <= CMD_NOP;
      cmd_bank_ff <= '0;
      cmd_addr_ff <= '0;
      auto_pre_ff <= 1'b0;
      pre_all_ff <= 1'b0;
    end
    else
    begin
      cmd_strobe_ff <= cmd_go && cmd_w != CMD_NOP;
      if (cmd_go)
      begin
        cmd_kind_ff <= cmd_w;
        cmd_bank_ff <= bank_lk_ff;
        cmd_addr_ff <= addr_lk_ff;
        auto_pre_ff <= (cmd_w == CMD_READ || cmd_w == CMD_WRITE)
          && addr_lk_ff[AP_BIT];
        pre_all_ff <= cmd_w == CMD_PRECHARGE && addr_lk_ff[AP_BIT];
      end
    end
  end

  // ----------------------------------------
  // bank state
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bank_open_ff <= '0;
    else if (cmd_go)
    begin
      case (cmd_w)
        CMD_ACTIVATE: bank_open_ff[bank_lk_ff] <= 1'b1;
        CMD_READ, CMD_WRITE:
          if (addr_lk_ff[AP_BIT])
            bank_open_ff[bank_lk_ff] <= 1'b0;
        CMD_PRECHARGE:
          if (addr_lk_ff[AP_BIT])
            bank_open_ff <= '0;
          else
            bank_open_ff[bank_lk_ff] <= 1'b0;
        default: bank_open_ff <= bank_open_ff;
      endcase
    end
  end

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  logic [ADDR_W-1:0] mode_reg_ff [NUM_MODE_REGS];
  logic lmr_go;

  assign lmr_go = cmd_go && cmd_w == CMD_LOAD_MODE && !bank_lk_ff[2];

  for (genvar i = 0; i < NUM_MODE_REGS; i++)
  begin : g_mode
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        mode_reg_ff[i] <= MODE_REG_RST;
      else if (lmr_go && bank_lk_ff[1:0] == 2'(i))
        mode_reg_ff[i] <= addr_lk_ff;
    end
  end
  assign base_mode_reg = mode_reg_ff[SEL_BASE_MODE];
  assign ext_mode_reg_1 = mode_reg_ff[SEL_EXT_MODE_1];
  assign ext_mode_reg_2 = mode_reg_ff[SEL_EXT_MODE_2];
  assign ext_mode_reg_3 = mode_reg_ff[SEL_EXT_MODE_3];

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  scaci_pwr_t nxt_pwr_state;

  always_comb
  begin
    nxt_pwr_state = pwr_state_ff;
    case (pwr_state_ff)
      PW_ACTIVE:
        if (new_word && !cke_lk_ff)
        begin
          if (any_open)
            nxt_pwr_state = PW_ACT_PD;
          else if (sr_entry)
            nxt_pwr_state = PW_SELF_REF;
          else
            nxt_pwr_state = PW_PRE_PD;
        end
      PW_PRE_PD, PW_ACT_PD:
        if (new_word && cke_lk_ff)
          nxt_pwr_state = PW_ACTIVE;
      PW_SELF_REF:
        if (cke_async_s)
          nxt_pwr_state = PW_ACTIVE;
      default: nxt_pwr_state = PW_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pwr_state_ff <= PW_ACTIVE;
    else
      pwr_state_ff <= nxt_pwr_state;
  end

  assign gate_sys = {pwr_state_ff == PW_SELF_REF,
    pwr_state_ff == PW_PRE_PD || pwr_state_ff == PW_ACT_PD};

  // ----------------------------------------
  // clocking, output and termination enables
  // ----------------------------------------
  logic term_disabled;
  logic word_cke_ff;
  logic word_term_ff;
  assign term_disabled = ext_mode_reg_1[TERM_DIS_BIT];

  // link levels taken only while the word is known stable
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_cke_ff <= 1'b0;
      word_term_ff <= 1'b0;
    end
    else if (new_word)
    begin
      word_cke_ff <= cke_lk_ff;
      word_term_ff <= term_lk_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_clk_en_ff <= 1'b0;
      out_enable_ff <= 1'b0;
      term_enable_ff <= 1'b0;
      data_launch_ff <= 1'b0;
    end
    else
    begin
      int_clk_en_ff <= nxt_pwr_state == PW_ACTIVE;
      out_enable_ff <= nxt_pwr_state == PW_ACTIVE && word_cke_ff;
      term_enable_ff <= word_term_ff && !term_disabled
        && pwr_state_ff != PW_SELF_REF;
      data_launch_ff <= new_word && pwr_state_ff == PW_ACTIVE;
    end
  end

  // ----------------------------------------
  // link clock activity watch
  // ----------------------------------------
  logic comp_q_ff;
  logic [15:0] idle_cnt_ff;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp_q_ff <= 1'b0;
      idle_cnt_ff <= '0;
      link_clock_running_ff <= 1'b0;
    end
    else
    begin
      comp_q_ff <= comp_s;
      if (comp_q_ff != comp_s)
        idle_cnt_ff <= '0;
      else if (idle_cnt_ff != 16'(LINK_IDLE))
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      link_clock_running_ff <= idle_cnt_ff != 16'(LINK_IDLE);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence act_seen;
    cmd_go && cmd_w == CMD_ACTIVATE;
  endsequence

  sequence bank_then_open;
    ##1 bank_open_ff[cmd_bank_ff] && cmd_kind_ff == CMD_ACTIVATE;
  endsequence

  act_open_a: assert property (act_seen |-> bank_then_open)
    else $error("activate did not open bank");

  autopre_close_a: assert property (
    cmd_go && cmd_w == CMD_READ && addr_lk_ff[AP_BIT]
    |=> !bank_open_ff[cmd_bank_ff] && auto_pre_ff)
    else $error("auto precharge did not close bank");

  pre_one_a: assert property (
    cmd_go && cmd_w == CMD_PRECHARGE && !addr_lk_ff[AP_BIT]
    |=> !bank_open_ff[cmd_bank_ff] && !pre_all_ff)
    else $error("single bank precharge wrong");

  pre_all_a: assert property (
    cmd_go && cmd_w == CMD_PRECHARGE && addr_lk_ff[AP_BIT] |=> bank_open_ff == '0)
    else $error("all bank precharge left a bank open");

  mode_load_a: assert property (
    lmr_go && bank_lk_ff[1:0] == SEL_EXT_MODE_2
    |=> ext_mode_reg_2 == $past(addr_lk_ff) && $stable(base_mode_reg))
    else $error("mode load went to wrong register");

  cs_mask_a: assert property (new_word && cs_n_lk_ff |=> !cmd_strobe_ff)
    else $error("command passed with chip select high");

  pd_entry_a: assert property (
    pwr_state_ff == PW_ACTIVE && new_word && !cke_lk_ff && any_open
    |=> pwr_state_ff == PW_ACT_PD ##1 !int_clk_en_ff)
    else $error("active power-down not entered");

  sr_exit_a: assert property (
    pwr_state_ff == PW_SELF_REF && cke_async_s |=> pwr_state_ff == PW_ACTIVE)
    else $error("self refresh exit missed");

  term_gate_a: assert property (
    term_disabled && $past(term_disabled) |-> !term_enable_ff)
    else $error("termination on while disabled");

  pd_mask_a: assert property (
    pwr_state_ff != PW_ACTIVE |=> !cmd_strobe_ff)
    else $error("command decoded in power-down");

endmodule // scaci_input_stage

// File: rtl/scaci_sync.sv
`timescale 1ns/100ps
module scaci_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // ----------------------------------------
  // two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule // scaci_sync

// File: test/scaci_ctrl_model.sv
`timescale 1ns/100ps
module scaci_ctrl_model
  import scaci_pkg::*;
(
  output logic diff_clock_true,
  output logic diff_clock_comp,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ADDR_W-1:0] row_col_address_bus,
  output logic [BANK_W-1:0] bank_select,
  output logic cke,
  output logic termination_ctrl
);
  // ----------------------------------------
  // controller side: link clock and pins
  // ----------------------------------------
  logic link_run = 1'b1;

  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    row_col_address_bus = '0;
    bank_select = '0;
    cke = 1'b1;
    termination_ctrl = 1'b0;
    diff_clock_true = 1'b0;
    diff_clock_comp = 1'b1;
    #3.7;
    forever
    begin
      #62.5;
      // stops only in the low phase
      if (link_run || diff_clock_true)
      begin
        diff_clock_true = ~diff_clock_true;
        diff_clock_comp = ~diff_clock_true;
      end
    end
  end

  task idle(input int n);
    repeat (n) @(posedge diff_clock_true);
  endtask

  task set_run(input logic v);
    link_run = v;
  endtask

  task set_cke(input logic v);
    cke = v;
  endtask

  task set_term(input logic v);
    @(posedge diff_clock_true);
    #1;
    termination_ctrl = v;
  endtask

  task issue(input scaci_cmd_t cmd, input logic [BANK_W-1:0] ba,
             input logic [ADDR_W-1:0] a, input logic sel_n, input logic ce);
    @(posedge diff_clock_true);
    #1;
    {ras_n, cas_n, we_n} = cmd;
    cs_n = sel_n;
    bank_select = ba;
    row_col_address_bus = a;
    cke = ce;
    @(posedge diff_clock_true);
    #1;
    // hold time over: pins no longer show the word
    {ras_n, cas_n, we_n} = CMD_NOP;
    cs_n = 1'b0;
    bank_select = ~ba;
    row_col_address_bus = ~a;
  endtask
endmodule // scaci_ctrl_model

// File: test/sdram_cmd_addr_cke_input_test.sv
`timescale 1ns/100ps
module sdram_cmd_addr_cke_input_test
  import scaci_pkg::*;
;
  localparam int LINK_IDLE = 20;
  typedef struct packed {
    scaci_cmd_t cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] a;
    logic [NUM_BANKS-1:0] open;
  } scaci_row_t;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic diff_clock_true, diff_clock_comp, cs_n, ras_n, cas_n, we_n, cke, termination_ctrl;
  logic [ADDR_W-1:0] row_col_address_bus, cmd_addr_ff;
  logic [BANK_W-1:0] bank_select, cmd_bank_ff;
  logic cmd_strobe_ff, auto_pre_ff, pre_all_ff, int_clk_en_ff, out_enable_ff;
  logic term_enable_ff, data_launch_ff, link_clock_running_ff;
  scaci_cmd_t cmd_kind_ff;
  scaci_pwr_t pwr_state_ff;
  logic [NUM_BANKS-1:0] bank_open_ff;
  logic [ADDR_W-1:0] base_mode_reg, ext_mode_reg_1, ext_mode_reg_2, ext_mode_reg_3;
  int num_errors = 0;
  int check_count = 0;
  int strobes = 0;
  int launches = 0;
  int n;
  scaci_row_t rows [14] = '{
    '{CMD_LOAD_MODE, 3'h0, 14'h1234, 8'h00},
    '{CMD_LOAD_MODE, 3'h1, 14'h0005, 8'h00},
    '{CMD_LOAD_MODE, 3'h2, 14'h2AAA, 8'h00},
    '{CMD_LOAD_MODE, 3'h3, 14'h1555, 8'h00},
    '{CMD_ACTIVATE, 3'h3, 14'h2ABC, 8'h08},
    '{CMD_ACTIVATE, 3'h5, 14'h3FFF, 8'h28},
    '{CMD_READ, 3'h3, 14'h0400, 8'h20},
    '{CMD_WRITE, 3'h5, 14'h0010, 8'h20},
    '{CMD_PRECHARGE, 3'h5, 14'h0000, 8'h00},
    '{CMD_ACTIVATE, 3'h0, 14'h0001, 8'h01},
    '{CMD_ACTIVATE, 3'h7, 14'h0002, 8'h81},
    '{CMD_PRECHARGE, 3'h2, 14'h0400, 8'h00},
    '{CMD_REFRESH, 3'h0, 14'h0000, 8'h00},
    '{CMD_TERMINATE, 3'h1, 14'h0003, 8'h00}
  };

  always #5 clk_sys = ~clk_sys;

  always @(negedge clk_sys)
  begin
    if (cmd_strobe_ff === 1'b1)
      strobes++;
    if (data_launch_ff === 1'b1)
      launches++;
  end

  scaci_ctrl_model ctrl (
    .diff_clock_true(diff_clock_true),
    .diff_clock_comp(diff_clock_comp),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .row_col_address_bus(row_col_address_bus),
    .bank_select(bank_select),
    .cke(cke),
    .termination_ctrl(termination_ctrl)
  );

  scaci_input_stage #(.LINK_IDLE(LINK_IDLE)) dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .diff_clock_true(diff_clock_true),
    .diff_clock_comp(diff_clock_comp),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .row_col_address_bus(row_col_address_bus),
    .bank_select(bank_select),
    .cke(cke),
    .termination_ctrl(termination_ctrl),
    .cmd_strobe_ff(cmd_strobe_ff),
    .cmd_kind_ff(cmd_kind_ff),
    .cmd_bank_ff(cmd_bank_ff),
    .cmd_addr_ff(cmd_addr_ff),
    .auto_pre_ff(auto_pre_ff),
    .pre_all_ff(pre_all_ff),
    .bank_open_ff(bank_open_ff),
    .base_mode_reg(base_mode_reg),
    .ext_mode_reg_1(ext_mode_reg_1),
    .ext_mode_reg_2(ext_mode_reg_2),
    .ext_mode_reg_3(ext_mode_reg_3),
    .pwr_state_ff(pwr_state_ff),
    .int_clk_en_ff(int_clk_en_ff),
    .out_enable_ff(out_enable_ff),
    .term_enable_ff(term_enable_ff),
    .data_launch_ff(data_launch_ff),
    .link_clock_running_ff(link_clock_running_ff)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task go(input scaci_cmd_t c, input logic [2:0] ba, input logic [13:0] a,
          input logic sel_n, input logic ce);
    n = strobes;
    ctrl.issue(c, ba, a, sel_n, ce);
    repeat (8) @(posedge clk_sys);
    #1;
  endtask

  task complete_run;
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    num_errors++;
    complete_run;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    repeat (3) @(posedge diff_clock_true);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    ctrl.idle(3);
    foreach (rows[i])
    begin
      go(rows[i].cmd, rows[i].ba, rows[i].a, 1'b0, 1'b1);
      chk("strobe", 16'(n + 1), 16'(strobes));
      chk("kind", rows[i].cmd, cmd_kind_ff);
      chk("bank", rows[i].ba, cmd_bank_ff);
      chk("addr", rows[i].a, cmd_addr_ff);
      chk("open", rows[i].open, bank_open_ff);
      if (rows[i].cmd == CMD_READ || rows[i].cmd == CMD_WRITE)
        chk("auto_pre", rows[i].a[AP_BIT], auto_pre_ff);
      if (rows[i].cmd == CMD_PRECHARGE)
        chk("pre_all", rows[i].a[AP_BIT], pre_all_ff);
    end
    go(CMD_LOAD_MODE, 3'h4, 14'h3333, 1'b0, 1'b1);
    chk("mr0", 14'h1234, base_mode_reg);
    chk("mr1", 14'h0005, ext_mode_reg_1);
    chk("mr2", 14'h2AAA, ext_mode_reg_2);
    chk("mr3", 14'h1555, ext_mode_reg_3);
    go(CMD_ACTIVATE, 3'h4, 14'h0044, 1'b1, 1'b1);
    chk("masked", 16'(n), 16'(strobes));
    chk("masked_open", 8'h00, bank_open_ff);
    ctrl.set_term(1'b1);
    go(CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b1);
    chk("term_on", 1'b1, term_enable_ff);
    go(CMD_LOAD_MODE, 3'h1, 14'h0045, 1'b0, 1'b1);
    ctrl.idle(2);
    chk("term_off", 1'b0, term_enable_ff);
    go(CMD_ACTIVATE, 3'h2, 14'h0100, 1'b0, 1'b1);
    go(CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b0);
    chk("act_pd", PW_ACT_PD, pwr_state_ff);
    chk("clk_off", 1'b0, int_clk_en_ff);
    chk("oe_off", 1'b0, out_enable_ff);
    ctrl.idle(2);
    go(CMD_ACTIVATE, 3'h6, 14'h0200, 1'b0, 1'b0);
    chk("pd_ignore", 16'(n), 16'(strobes));
    go(CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b1);
    chk("pd_exit", PW_ACTIVE, pwr_state_ff);
    chk("clk_on", 1'b1, int_clk_en_ff);
    chk("oe_on", 1'b1, out_enable_ff);
    ctrl.idle(2);
    go(CMD_PRECHARGE, 3'h0, 14'h0400, 1'b0, 1'b1);
    go(CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b0);
    chk("pre_pd", PW_PRE_PD, pwr_state_ff);
    ctrl.idle(2);
    n = launches;
    ctrl.idle(4);
    chk("launch_pd", 16'(n), 16'(launches));
    go(CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b1);
    ctrl.idle(2);
    n = launches;
    ctrl.idle(4);
    chk("launch", 16'(n + 4), 16'(launches));
    go(CMD_REFRESH, 3'h0, 14'h0000, 1'b0, 1'b0);
    chk("self_ref", PW_SELF_REF, pwr_state_ff);
    ctrl.idle(2);
    go(CMD_ACTIVATE, 3'h1, 14'h0300, 1'b0, 1'b0);
    chk("sr_ignore", 16'(n), 16'(strobes));
    ctrl.set_run(1'b0);
    repeat (LINK_IDLE + 10) @(posedge clk_sys);
    #1;
    chk("link_stop", 1'b0, link_clock_running_ff);
    ctrl.set_cke(1'b1);
    repeat (8) @(posedge clk_sys);
    #1;
    chk("sr_exit", PW_ACTIVE, pwr_state_ff);
    ctrl.set_run(1'b1);
    ctrl.idle(3);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("link_run", 1'b1, link_clock_running_ff);
    rst_n = 1'b0;
    repeat (3) @(posedge diff_clock_true);
    #1;
    chk("rst_kind", CMD_NOP, cmd_kind_ff);
    chk("rst_pwr", PW_ACTIVE, pwr_state_ff);
    chk("rst_mr0", 14'h0000, base_mode_reg);
    chk("rst_open", 8'h00, bank_open_ff);
    complete_run;
  end
endmodule // sdram_cmd_addr_cke_input_test
